// ### bench/probe_model.sv
/*
 Probe side model: the circuit under test seen through the probes.
 Assumes the bench calls one task at a time, just after a clock edge.
*/
module probe_model (
   // Clock
   input wire logic ref_clk,
   // Probe lines
   output logic [7:0] chans,
   output logic qual
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      chans = 8'h00;
      qual = 1'b0;
   end
   task automatic drive(input logic [7:0] v, input logic q, input int n);
      chans <= v;
      qual <= q;
      repeat (n) @(posedge ref_clk);
   endtask
   // Pulses of one cycle would be filtered away, so w is 2 or more
   task automatic glitch(input int ch, input int w);
      chans[ch] <= ~chans[ch];
      repeat (w) @(posedge ref_clk);
      chans[ch] <= ~chans[ch];
      repeat (6) @(posedge ref_clk);
   endtask
   // Transitions on channel 7 feed the final delay count
   task automatic toggle(input int n);
      repeat (n) begin
         chans[7] <= ~chans[7];
         repeat (3) @(posedge ref_clk);
      end
   endtask
endmodule

// ### bench/timing_trigger_glitch_window_props.sv
/*
 Port checker of the trigger unit.
 Bound to every instance of timing_trigger_glitch_window.
*/
module trig_port_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Trigger state
   input wire logic trigger_out,
   input wire logic acq_done,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   property p_wr_resp;
      awvalid && awready && wvalid && wready |-> ##2 bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
   property p_rd_resp;
      arvalid && arready |=> rvalid;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
   property p_b_hold;
      bvalid && !bready |=> bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   property p_r_hold;
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data moved");
   property p_ar_block;
      rvalid |-> !arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("arready during rvalid");
   // Done never stands without the trigger that led to it
   property p_done_trig;
      acq_done |-> trigger_out;
   endproperty
   a_done_trig: assert property (p_done_trig) else $error("done without trigger");
   property p_rst_rel;
      $fell(rst) |-> !trigger_out && !acq_done;
   endproperty
   a_rst_rel: assert property (p_rst_rel) else $error("flags set after reset");
   property p_trig_first;
      $rose(trigger_out) |-> !acq_done ##1 !acq_done;
   endproperty
   a_trig_first: assert property (p_trig_first) else $error("done with trigger");
endmodule
bind timing_trigger_glitch_window trig_port_checker trig_port_checker_i (.ref_clk, .rst,
   .trigger_out, .acq_done, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
   .arvalid, .arready, .rdata, .rvalid, .rready);

// ### bench/timing_trigger_glitch_window_tb.sv
/*
 Self-checking bench of the trigger unit: registers, presets, word,
 glitch-in-word and glitch-in-window triggering.
 Assumes probe_model on the probe pins and the bound port checker.
*/
module timing_trigger_glitch_window_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import trig_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   wire logic [7:0] chans;
   wire logic qual;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, v;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, trigger_out, acq_done;
   logic [1:0] bresp, rresp;
   int seed = 87, n_errors = 0, checks = 0, cyc = 0;
   always #5 ref_clk = ~ref_clk;
   probe_model probe_model_i (.ref_clk, .chans, .qual);
   timing_trigger_glitch_window #(.MAX_DELAY_CYC_P(64)) timing_trigger_glitch_window_i (
      .ref_clk, .rst, .channel_pattern_bits(chans), .external_qualifier(qual),
      .trigger_out, .acq_done, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready);
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
      logic awp, wp;
      int k;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      awp = 1'b1;
      wp = 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
         if (awp && awready === 1'b1) begin
            awvalid <= 1'b0;
            awp = 1'b0;
         end
         if (wp && wready === 1'b1) begin
            wvalid <= 1'b0;
            wp = 1'b0;
         end
      end while ((awp || wp || bvalid !== 1'b1) && k < 200);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dat, input logic [1:0] er);
      logic arp;
      int k;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      arp = 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
         if (arp && arready === 1'b1) begin
            arvalid <= 1'b0;
            arp = 1'b0;
         end
      end while ((arp || rvalid !== 1'b1) && k < 200);
      dat = rdata;
      rready <= 1'b0;
      chk({30'h0, rresp}, {30'h0, er});
   endtask
   // Waits up to n cycles for the flag, then compares it
   task automatic fwait(input logic sel, input logic e, input int n);
      repeat (n) if ((sel ? acq_done : trigger_out) !== 1'b1) @(posedge ref_clk);
      chk({31'h0, sel ? acq_done : trigger_out}, {31'h0, e});
   endtask
   function automatic logic [31:0] fin(input int p);
      case (p)
         1: fin = 32'h19;
         2: fin = 32'h7F;
         default: fin = 32'hE6;
      endcase
   endfunction
   // Arm with qualifier compared against one
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic af);
      ctl = 32'h301 | {27'h0, af, m, 2'h0};
   endfunction
   ////////////////////////////////////////
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      rd(OFS_VALID, d, RESP_OKAY);
      chk(d, 32'h14);
      rd(OFS_GLIM, d, RESP_OKAY);
      chk(d, 32'h2);
      rd(OFS_PATTERN, d, RESP_OKAY);
      chk(d, 32'h00FF0000);
      rd(8'h40, d, RESP_SLVERR);
      chk(d, 32'h0);
      wr(8'h44, 32'h5, RESP_SLVERR);
      for (int p = 1; p < 4; p++) begin
         wr(OFS_CTRL, 32'(p) << 10, RESP_OKAY);
         rd(OFS_FINAL, d, RESP_OKAY);
         chk(d, fin(p));
      end
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
         wr(OFS_FINAL, {24'h0, v}, RESP_OKAY);
         rd(OFS_FINAL, d, RESP_OKAY);
         chk(d, {24'h0, v});
      end
      v = 8'($random(seed));
      wr(OFS_PATTERN, {16'h00FF, 8'hFF, v}, RESP_OKAY);
      wr(OFS_VALID, 32'h5, RESP_OKAY);
      wr(OFS_GLIM, 32'h4, RESP_OKAY);
      wr(OFS_DELAY, 32'h2, RESP_OKAY);
      wr(OFS_FINAL, 32'h3, RESP_OKAY);
      wr(OFS_CTRL, ctl(MODE_WORD, 1'b0), RESP_OKAY);
      probe_model_i.drive(v, 1'b0, 20);
      fwait(1'b0, 1'b0, 1);
      probe_model_i.drive(v, 1'b1, 3);
      probe_model_i.drive(~v, 1'b1, 10);
      fwait(1'b0, 1'b0, 1);
      probe_model_i.drive(v, 1'b1, 2);
      fwait(1'b0, 1'b1, 40);
      probe_model_i.toggle(12);
      fwait(1'b1, 1'b1, 60);
      rd(OFS_STATUS, d, RESP_OKAY);
      chk({29'h0, d[2:0]}, 32'h6);
      wr(OFS_CTRL, ctl(MODE_WORD, 1'b1), RESP_OKAY);
      probe_model_i.drive(v, 1'b1, 12);
      fwait(1'b0, 1'b0, 1);
      probe_model_i.drive(~v, 1'b1, 1);
      fwait(1'b0, 1'b1, 20);
      wr(OFS_CTRL, 32'h2, RESP_OKAY);
      wr(OFS_PATTERN, {16'h00FF, 8'hFF, v ^ 8'h01}, RESP_OKAY);
      wr(OFS_CTRL, ctl(MODE_GLITCH_WORD, 1'b0), RESP_OKAY);
      probe_model_i.drive(v, 1'b1, 10);
      probe_model_i.glitch(0, 8);
      fwait(1'b0, 1'b0, 1);
      probe_model_i.glitch(0, 3);
      fwait(1'b0, 1'b1, 20);
      wr(OFS_CTRL, 32'h2, RESP_OKAY);
      wr(OFS_PATTERN, {16'h00FF, 8'hFF, v}, RESP_OKAY);
      wr(OFS_DELAY, 32'h14, RESP_OKAY);
      wr(OFS_CTRL, ctl(MODE_GLITCH_WINDOW, 1'b1), RESP_OKAY);
      // First pass lets the window run out, second glitches inside it
      for (int i = 0; i < 2; i++) begin
         probe_model_i.drive(v, 1'b1, 10);
         probe_model_i.drive(v ^ 8'hF0, 1'b1, 8 + 40 * (1 - i));
         probe_model_i.glitch(0, 3);
         fwait(1'b0, 1'(i), 20);
      end
      results();
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         $display("ERROR at %0t: timeout", $time);
         results();
      end
   end
endmodule

// ### verilog/glitch_detector.sv
/*
 Glitch detector on one filtered timing channel: flags the trailing
 edge of a pulse no longer than the programmed limit.
 Assumes the line is already synchronised to ref_clk.
*/
module glitch_detector (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Core side
   glitch_if.det gl
);
   import trig_pkg::*;

   typedef struct packed {
      logic prev;
      logic seen;
      logic [RUN_W-1:0] run;
      logic trail;
   } det_s;

   det_s st_r;
   det_s st_nxt;
   logic [RUN_W-1:0] len;

   always_comb begin
      len = st_r.run;
      st_nxt = st_r;
      st_nxt.trail = 1'b0;
      st_nxt.prev = gl.line;
      st_nxt.run = sat_inc(st_r.run);
      if (!gl.enable) begin
         st_nxt.seen = 1'b0;
      end else if (gl.line != st_r.prev) begin
         // Capture never sees a pulse narrower than the minimum width
         if (st_r.run < GLITCH_MIN_CYC) begin
            len = GLITCH_MIN_CYC;
         end
         if (st_r.seen && len <= gl.limit) begin
            st_nxt.trail = 1'b1;
         end
         st_nxt.seen = 1'b1;
         st_nxt.run = 16'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign gl.trail = st_r.trail;
endmodule

// ### verilog/glitch_if.sv
/*
 Link between the trigger core and its glitch detector.
 Assumes both ends run on the same clock.
*/
interface glitch_if;
   logic line;
   logic enable;
   logic [15:0] limit;
   logic trail;
   modport det (input line, input enable, input limit, output trail);
   modport user (output line, output enable, output limit, input trail);
endinterface

// ### verilog/timing_trigger_glitch_window.sv
/*
 Timing analyzer trigger unit: word match with valid time, glitch in
 word or in window, time delay, final delay in transitions, and the
 acquisition memory that it stops. Registers sit on AXI4-Lite.
 Assumes probe inputs are asynchronous and ref_clk runs at 100 MHz.
*/
// Design decisions made here: the register offsets and the AXI4-Lite register port.
//////////////////////////////////////////////////////////////////////
module timing_trigger_glitch_window #(
   parameter int MAX_DELAY_CYC_P = trig_pkg::MAX_DELAY_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Probe inputs
   input wire logic [trig_pkg::CH_N-1:0] channel_pattern_bits,
   input wire logic external_qualifier,
   // Trigger state
   output logic trigger_out,
   output logic acq_done,
   // AXI4-Lite write
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   import trig_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_SEEK, S_HELD, S_WINDOW, S_TDELAY, S_FINAL, S_DONE
   } state_e;

   typedef struct packed {
      logic [SAMP_W-1:0] s1;
      logic [SAMP_W-1:0] s2;
      logic [SAMP_W-1:0] s3;
      logic [SAMP_W-1:0] filt;
      state_e state;
      logic [RUN_W-1:0] run;
      logic [DLY_W-1:0] dcnt;
      logic [7:0] tcnt;
      logic triggered;
      logic done;
      logic [MEM_AW-1:0] wr_ptr;
      logic [MEM_AW-1:0] trig_ptr;
      logic [1:0] mode;
      logic after;
      logic [2:0] gch;
      logic q_care;
      logic q_val;
      logic [CH_N-1:0] pat_val;
      logic [CH_N-1:0] pat_care;
      logic [CH_N-1:0] ch_en;
      logic [RUN_W-1:0] valid_t;
      logic [RUN_W-1:0] glim;
      logic [DLY_W-1:0] delay;
      logic [7:0] final_d;
      logic [MEM_AW-1:0] mem_addr;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_full;
      logic w_full;
      logic [7:0] waddr;
      logic [31:0] wdat;
      logic [3:0] wstb;
   } state_s;

   localparam state_s ST_RST = '{
      state: S_IDLE,
      ch_en: CH_EN_RST,
      valid_t: VALID_RST,
      glim: GLIM_RST,
      final_d: FINAL_RST,
      default: '0
   };
   localparam logic [DLY_W-1:0] DELAY_MAX = DLY_W'(MAX_DELAY_CYC_P);

   state_s st_r;
   state_s st_nxt;
   logic [SAMP_W-1:0] mem [0:(1 << MEM_AW)-1];
   logic [SAMP_W-1:0] mem_rd;
   logic mem_we;
   logic tr;
   logic gmode;
   logic acquiring;
   logic match;
   logic valid_met;
   logic fire;
   logic arm;
   logic abort;
   logic [CH_N-1:0] care;
   logic [RUN_W-1:0] run_n;
   logic [DLY_W-1:0] dinc;
   logic [32:0] rd_w;
   logic [32:0] rd_r;
   logic [31:0] wd;

   glitch_if gl ();

   glitch_detector u_glitch (
      .ref_clk(ref_clk),
      .rst(rst),
      .gl(gl)
   );

   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] stb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (stb[i]) begin
            m[8*i +: 8] = nw[8*i +: 8];
         end
      end
      merge = m;
   endfunction

   // Returns {hit, data} for a register address
   function automatic logic [32:0] reg_rd(input state_s s,
                                          input logic [7:0] a,
                                          input logic [SAMP_W-1:0] mw);
      logic [31:0] v;
      logic hit;
      v = '0;
      hit = 1'b1;
      case (a)
         OFS_CTRL: begin
            v[CTRL_MODE_LSB +: 2] = s.mode;
            v[CTRL_AFTER] = s.after;
            v[CTRL_GCH_LSB +: 3] = s.gch;
            v[CTRL_QCARE] = s.q_care;
            v[CTRL_QVAL] = s.q_val;
         end
         OFS_PATTERN: begin
            v[PAT_VAL_LSB +: CH_N] = s.pat_val;
            v[PAT_CARE_LSB +: CH_N] = s.pat_care;
            v[PAT_EN_LSB +: CH_N] = s.ch_en;
         end
         OFS_VALID: v[RUN_W-1:0] = s.valid_t;
         OFS_GLIM: v[RUN_W-1:0] = s.glim;
         OFS_DELAY: v[DLY_W-1:0] = s.delay;
         OFS_FINAL: v[7:0] = s.final_d;
         OFS_STATUS: begin
            v[ST_BUSY] = (s.state != S_IDLE) && (s.state != S_DONE);
            v[ST_DONE] = s.done;
            v[ST_TRIG] = s.triggered;
            v[ST_TPTR_LSB +: MEM_AW] = s.trig_ptr;
            v[ST_WPTR_LSB +: MEM_AW] = s.wr_ptr;
         end
         OFS_MEM_ADDR: v[MEM_AW-1:0] = s.mem_addr;
         OFS_MEM_DATA: v[SAMP_W-1:0] = mw;
         default: hit = 1'b0;
      endcase
      reg_rd = {hit, v};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Glitch detector hookup
   assign gmode = (st_r.mode == MODE_GLITCH_WORD) || (st_r.mode == MODE_GLITCH_WINDOW);
   assign acquiring = (st_r.state != S_IDLE) && (st_r.state != S_DONE);
   assign gl.line = st_r.filt[st_r.gch];
   assign gl.enable = gmode && acquiring;
   assign gl.limit = st_r.glim;
   assign mem_rd = mem[st_r.mem_addr];

   always_comb begin
      st_nxt = st_r;
      tr = 1'b0;
      mem_we = 1'b0;
      fire = 1'b0;
      arm = 1'b0;
      abort = 1'b0;
      rd_w = '0;
      rd_r = '0;
      wd = '0;

      // Three-stage input sync; a change counts when stages two and three agree
      st_nxt.s1 = {external_qualifier, channel_pattern_bits};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3 && st_r.s3 != st_r.filt) begin
         st_nxt.filt = st_r.s3;
         tr = 1'b1;
      end

      // Word compare: disabled channels drop out, and in glitch modes the glitch channel too
      care = st_r.pat_care & st_r.ch_en;
      if (gmode) begin
         care = care & ~(8'h01 << st_r.gch);
      end
      match = (((st_r.filt[CH_N-1:0] ^ st_r.pat_val) & care) == '0)
         && (!st_r.q_care || st_r.filt[CH_N] == st_r.q_val);
      run_n = match ? sat_inc(st_r.run) : '0;
      st_nxt.run = run_n;
      valid_met = match && (run_n >= st_r.valid_t);
      dinc = st_r.dcnt + 21'h000001;

      case (st_r.state)
         S_IDLE: begin
         end
         S_SEEK: begin
            if (valid_met) begin
               case (st_r.mode)
                  MODE_GLITCH_WORD: begin
                     if (gl.trail) begin
                        fire = 1'b1;
                     end else begin
                        st_nxt.state = S_HELD;
                     end
                  end
                  MODE_GLITCH_WINDOW: begin
                     if (st_r.after) begin
                        st_nxt.state = S_HELD;
                     end else begin
                        st_nxt.state = S_WINDOW;
                        st_nxt.dcnt = '0;
                     end
                  end
                  default: begin
                     if (st_r.after) begin
                        st_nxt.state = S_HELD;
                     end else begin
                        fire = 1'b1;
                     end
                  end
               endcase
            end
         end
         S_HELD: begin
            if (!match) begin
               case (st_r.mode)
                  MODE_GLITCH_WORD: st_nxt.state = S_SEEK;
                  MODE_GLITCH_WINDOW: begin
                     st_nxt.state = S_WINDOW;
                     st_nxt.dcnt = '0;
                  end
                  default: fire = 1'b1;
               endcase
            end else if (st_r.mode == MODE_GLITCH_WORD && gl.trail) begin
               fire = 1'b1;
            end
         end
         S_WINDOW: begin
            if (gl.trail) begin
               fire = 1'b1;
            end else if (st_r.dcnt >= st_r.delay) begin
               st_nxt.state = S_SEEK;
            end else begin
               st_nxt.dcnt = dinc;
            end
         end
         S_TDELAY: begin
            if (st_r.dcnt >= st_r.delay) begin
               st_nxt.state = S_FINAL;
               st_nxt.tcnt = '0;
            end else begin
               st_nxt.dcnt = dinc;
            end
         end
         S_FINAL: begin
            if (st_r.tcnt == st_r.final_d) begin
               st_nxt.state = S_DONE;
               st_nxt.done = 1'b1;
            end else if (tr) begin
               st_nxt.tcnt = st_r.tcnt + 8'h01;
            end
         end
         S_DONE: begin
         end
         default: st_nxt.state = S_IDLE;
      endcase

      // The window replaces the time delay, so window hits go straight to final
      if (fire) begin
         st_nxt.triggered = 1'b1;
         st_nxt.trig_ptr = st_r.wr_ptr;
         st_nxt.dcnt = '0;
         st_nxt.tcnt = '0;
         st_nxt.state = (st_r.mode == MODE_GLITCH_WINDOW) ? S_FINAL : S_TDELAY;
      end

      // Every transition is stored until the final delay is spent
      if (acquiring && tr) begin
         mem_we = 1'b1;
         st_nxt.wr_ptr = st_r.wr_ptr + 8'h01;
      end

      ////////////////////////////////////////////////////////////////
      // AXI4-Lite write: address and data latched in either order
      if (awvalid && st_r.awready) begin
         st_nxt.waddr = awaddr;
         st_nxt.aw_full = 1'b1;
      end
      if (wvalid && st_r.wready) begin
         st_nxt.wdat = wdata;
         st_nxt.wstb = wstrb;
         st_nxt.w_full = 1'b1;
      end
      if (st_r.aw_full && st_r.w_full && !st_r.bvalid) begin
         rd_w = reg_rd(st_r, st_r.waddr, mem_rd);
         wd = merge(rd_w[31:0], st_r.wdat, st_r.wstb);
         st_nxt.aw_full = 1'b0;
         st_nxt.w_full = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = rd_w[32] ? RESP_OKAY : RESP_SLVERR;
         case (st_r.waddr)
            OFS_CTRL: begin
               st_nxt.mode = wd[CTRL_MODE_LSB +: 2];
               st_nxt.after = wd[CTRL_AFTER];
               st_nxt.gch = wd[CTRL_GCH_LSB +: 3];
               st_nxt.q_care = wd[CTRL_QCARE];
               st_nxt.q_val = wd[CTRL_QVAL];
               arm = wd[CTRL_ARM];
               abort = wd[CTRL_ABORT];
               case (wd[CTRL_PRESET_LSB +: 2])
                  PRESET_PRE: st_nxt.final_d = FINAL_PRE;
                  PRESET_CENTERED_CAPTURE_PRESET: st_nxt.final_d = FINAL_CENTERED_CAPTURE_PRESET;
                  PRESET_POST: st_nxt.final_d = FINAL_POST;
                  default: begin
                  end
               endcase
            end
            OFS_PATTERN: begin
               st_nxt.pat_val = wd[PAT_VAL_LSB +: CH_N];
               st_nxt.pat_care = wd[PAT_CARE_LSB +: CH_N];
               st_nxt.ch_en = wd[PAT_EN_LSB +: CH_N];
            end
            OFS_VALID: st_nxt.valid_t = wd[RUN_W-1:0];
            OFS_GLIM: st_nxt.glim = wd[RUN_W-1:0];
            OFS_DELAY: begin
               // Long settings clip at the top of the range
               st_nxt.delay = (wd[DLY_W-1:0] > DELAY_MAX) ? DELAY_MAX : wd[DLY_W-1:0];
            end
            OFS_FINAL: st_nxt.final_d = wd[7:0];
            OFS_MEM_ADDR: st_nxt.mem_addr = wd[MEM_AW-1:0];
            default: begin
            end
         endcase
      end
      if (st_r.bvalid && bready) begin
         st_nxt.bvalid = 1'b0;
      end
      st_nxt.awready = !st_nxt.aw_full;
      st_nxt.wready = !st_nxt.w_full;

      // Arming mid-run is ignored, so done is never cleared while being set
      if (abort) begin
         st_nxt.state = S_IDLE;
      end else if (arm && !acquiring) begin
         st_nxt.state = S_SEEK;
         st_nxt.done = 1'b0;
         st_nxt.triggered = 1'b0;
         st_nxt.wr_ptr = '0;
         st_nxt.dcnt = '0;
         st_nxt.tcnt = '0;
      end

      ////////////////////////////////////////////////////////////////
      // AXI4-Lite read
      if (st_r.rvalid && rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (arvalid && st_r.arready) begin
         rd_r = reg_rd(st_r, araddr, mem_rd);
         st_nxt.rdata = rd_r[31:0];
         st_nxt.rresp = rd_r[32] ? RESP_OKAY : RESP_SLVERR;
         st_nxt.rvalid = 1'b1;
      end
      st_nxt.arready = !st_nxt.rvalid;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Capture memory is not reset; the write pointer says what is valid
   always_ff @(posedge ref_clk) begin
      if (mem_we) begin
         mem[st_r.wr_ptr] <= st_r.s3;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign trigger_out = st_r.triggered;
   assign acq_done = st_r.done;
   assign awready = st_r.awready;
   assign wready = st_r.wready;
   assign bvalid = st_r.bvalid;
   assign bresp = st_r.bresp;
   assign arready = st_r.arready;
   assign rvalid = st_r.rvalid;
   assign rresp = st_r.rresp;
   assign rdata = st_r.rdata;
endmodule

// ### verilog/trig_pkg.sv
/*
 Constants, register map and helpers of the timing trigger unit.
 Assumes a single 100 MHz clock; all times are counted in its cycles.
*/
package trig_pkg;
   // Clock and time figures
   localparam int CLK_PERIOD_NS = 10;
   localparam int GLITCH_MIN_NS = 20;
   localparam logic [15:0] GLITCH_MIN_CYC =
      16'((GLITCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int MAX_DELAY_MS = 20;
   localparam int MAX_DELAY_CYC = (MAX_DELAY_MS * 1000000) / CLK_PERIOD_NS;

   // Widths
   localparam int CH_N = 8;
   localparam int SAMP_W = 9;
   localparam int RUN_W = 16;
   localparam int DLY_W = 21;
   localparam int MEM_AW = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PATTERN = 8'h04;
   localparam logic [7:0] OFS_VALID = 8'h08;
   localparam logic [7:0] OFS_GLIM = 8'h0C;
   localparam logic [7:0] OFS_DELAY = 8'h10;
   localparam logic [7:0] OFS_FINAL = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_MEM_ADDR = 8'h1C;
   localparam logic [7:0] OFS_MEM_DATA = 8'h20;

   // Field positions
   localparam int CTRL_ARM = 0;
   localparam int CTRL_ABORT = 1;
   localparam int CTRL_MODE_LSB = 2;
   localparam int CTRL_AFTER = 4;
   localparam int CTRL_GCH_LSB = 5;
   localparam int CTRL_QCARE = 8;
   localparam int CTRL_QVAL = 9;
   localparam int CTRL_PRESET_LSB = 10;
   localparam int PAT_VAL_LSB = 0;
   localparam int PAT_CARE_LSB = 8;
   localparam int PAT_EN_LSB = 16;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_TRIG = 2;
   localparam int ST_TPTR_LSB = 8;
   localparam int ST_WPTR_LSB = 16;

   // Trigger modes and final delay presets
   localparam logic [1:0] MODE_WORD = 2'h0;
   localparam logic [1:0] MODE_GLITCH_WORD = 2'h1;
   localparam logic [1:0] MODE_GLITCH_WINDOW = 2'h2;
   localparam logic [1:0] PRESET_PRE = 2'h1;
   localparam logic [1:0] PRESET_CENTERED_CAPTURE_PRESET = 2'h2;
   localparam logic [1:0] PRESET_POST = 2'h3;
   localparam logic [7:0] FINAL_PRE = 8'h19;
   localparam logic [7:0] FINAL_CENTERED_CAPTURE_PRESET = 8'h7F;
   localparam logic [7:0] FINAL_POST = 8'hE6;

   // Reset values
   localparam logic [15:0] VALID_RST = 16'h0014;
   localparam logic [15:0] GLIM_RST = 16'h0002;
   localparam logic [7:0] CH_EN_RST = 8'hFF;
   localparam logic [7:0] FINAL_RST = 8'h7F;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic logic [RUN_W-1:0] sat_inc(input logic [RUN_W-1:0] v);
      sat_inc = (&v) ? v : v + 16'h0001;
   endfunction
endpackage
